// ---- shared/gkirq_pkg.sv ----
package gkirq_pkg;
   // register indices; byte address is four times the low twelve bits
   localparam logic [31:0] OFF_SEL_IRQ0 = 32'h50001400;
   localparam logic [31:0] OFF_SEL_IRQ1 = 32'h50001402;
   localparam logic [31:0] OFF_SEL_IRQ2 = 32'h50001404;
   localparam logic [31:0] OFF_SEL_IRQ3 = 32'h50001406;
   localparam logic [31:0] OFF_SEL_IRQ4 = 32'h50001408;
   localparam logic [31:0] OFF_DEBOUNCE = 32'h5000140c;
   localparam logic [31:0] OFF_IRQ_ACK = 32'h5000140e;
   localparam logic [31:0] OFF_POL_REARM = 32'h50001410;
   localparam logic [31:0] OFF_KEY_SEL0 = 32'h50001412;
   localparam logic [31:0] OFF_KEY_SEL1 = 32'h50001414;
   localparam logic [31:0] OFF_KEY_SEL2 = 32'h50001416;
   localparam logic [31:0] OFF_IRQ_STATUS = 32'h50001418;
   localparam logic [31:0] OFF_IRQ_MASK = 32'h5000141a;

   localparam int PADDR_W = 16;
   localparam int PIN_IRQS = 5;
   localparam int CHANNELS = 6;
   localparam int PINS = 32;
   localparam int SEL_W = 6;

   // writable bits and reset values
   localparam logic [15:0] POL_REARM_WMASK = 16'h1f1f;
   localparam logic [15:0] DEBOUNCE_WMASK = 16'h3f3f;
   localparam logic [15:0] KEY_SEL2_WMASK = 16'h00ff;
   localparam logic [15:0] REG_RESET = 16'h0000;
   localparam logic [5:0] SEL_RESET = 6'h00;

   // field positions
   localparam int REARM_LSB = 8;
   localparam int KEY_REPEAT_LSB = 8;
   localparam int KEY_POL_BIT = 14;
   localparam int KEY_REL_BIT = 15;
   localparam int DEB_EN_LSB = 8;
   localparam int DEB_PERIOD_LSB = 0;
   localparam int KEY_ACK_BIT = 5;
   localparam int PORT1_LSB = 10;

   // millisecond tick from the system clock
   localparam int CLK_PERIOD_NS = 40;
   localparam int MS_PERIOD_NS = 1000000;
   localparam int TICK_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
endpackage

// ---- hw/gkirq_debounce.sv ----
`timescale 1ns/1ps
module gkirq_debounce
   import gkirq_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic msTick,
   input wire logic enable,
   input wire logic [gkirq_pkg::SEL_W-1:0] period,
   input wire logic raw,
   output logic qual
);
   import gkirq_pkg::*;
   logic rawPrev;
   logic [SEL_W-1:0] count;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         rawPrev <= 1'b0;
         count <= '0;
      end
      else
      begin
         rawPrev <= raw;
         if (raw != rawPrev)
            count <= '0;
         else if (msTick && count < period)
            count <= count + 6'h01;
      end
   end

   // debounce qualification
   // first tick may come early, so the delay is between N-1 and N ms
   always_ff @(posedge clk)
   begin
      if (rst)
         qual <= 1'b0;
      else if (raw == rawPrev && raw != qual && (!enable || count >= period))
         qual <= raw;
   end

   deb_hold_a: assert property (@(posedge clk) disable iff (rst)
      (qual != $past(qual)) && $past(enable) |-> $past(count) >= $past(period))
      else $error("debounced level changed before its period elapsed");
   deb_release_a: assert property (@(posedge clk) disable iff (rst)
      $fell(qual) && $past(enable) |-> $past(raw, 2) == 1'b0)
      else $error("release passed debounce without a stable low input");
endmodule

// ---- hw/gkirq_logic.sv ----
`timescale 1ns/1ps
module gkirq_logic
   import gkirq_pkg::*;
#(
   parameter int TICK_CYCLES = gkirq_pkg::TICK_CYCLES
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [gkirq_pkg::PADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] port0,
   input wire logic [5:0] port1,
   input wire logic [9:0] port2,
   input wire logic [7:0] port3,
   output logic [gkirq_pkg::PIN_IRQS-1:0] pinIrq,
   output logic keypadInterrupt,
   output logic irq
);
   import gkirq_pkg::*;

   if (TICK_CYCLES < 2 || TICK_CYCLES > 65536)
   begin : g_bad_tick
      $error("TICK_CYCLES out of range");
   end

   function automatic logic regHit(input logic [PADDR_W-1:0] addr, input logic [31:0] idx);
      regHit = (addr[13:2] == idx[11:0]) && (addr[1:0] == 2'b00);
   endfunction

   function automatic logic pickPin(input logic [PINS-1:0] pins, input logic [SEL_W-1:0] sel);
      logic [SEL_W-1:0] pos;
      pos = sel - 6'h01;
      pickPin = (sel != 6'h00) && (sel <= 6'h20) && pins[pos[4:0]];
   endfunction

   // registers
   logic [SEL_W-1:0] irqSource [PIN_IRQS];
   logic [15:0] debounceCtrl, polRearm, keySel0, keySel1;
   logic [7:0] keySel2;
   logic [CHANNELS-1:0] irqStatus, irqMask;

   // bus strobes
   logic setupPhase, accessDone, wrDone, rdDone, addrHit;
   logic [15:0] readValue;

   // pin path
   logic [PINS-1:0] pinMeta, pinSync, keyEnable;
   logic [CHANNELS-1:0] rawActive, qualified;
   logic [PIN_IRQS-1:0] armed, pinSet, pinClr;

   // keypad path, its fields live in the port 0 select register
   logic keyRaw, keyDown, keyDownPrev, keyPress, keyRelease, repeatFire, keyEvent;
   logic [SEL_W-1:0] repeatCount, repeatPeriod;

   // tick
   logic [16:0] tickCount;
   logic msTick;

   assign setupPhase = psel && !penable;
   assign accessDone = psel && penable && pready;
   assign wrDone = accessDone && pwrite && !pslverr;
   assign rdDone = accessDone && !pwrite;
   assign repeatPeriod = keySel0[KEY_REPEAT_LSB +: SEL_W];

   always_comb
   begin
      addrHit = 1'b1;
      readValue = 16'h0000;
      if (regHit(paddr, OFF_SEL_IRQ0))
         readValue = {10'h000, irqSource[0]};
      else if (regHit(paddr, OFF_SEL_IRQ1))
         readValue = {10'h000, irqSource[1]};
      else if (regHit(paddr, OFF_SEL_IRQ2))
         readValue = {10'h000, irqSource[2]};
      else if (regHit(paddr, OFF_SEL_IRQ3))
         readValue = {10'h000, irqSource[3]};
      else if (regHit(paddr, OFF_SEL_IRQ4))
         readValue = {10'h000, irqSource[4]};
      else if (regHit(paddr, OFF_DEBOUNCE))
         readValue = debounceCtrl;
      else if (regHit(paddr, OFF_IRQ_ACK))
         readValue = 16'h0000;
      else if (regHit(paddr, OFF_POL_REARM))
         readValue = polRearm;
      else if (regHit(paddr, OFF_KEY_SEL0))
         readValue = keySel0;
      else if (regHit(paddr, OFF_KEY_SEL1))
         readValue = keySel1;
      else if (regHit(paddr, OFF_KEY_SEL2))
         readValue = {8'h00, keySel2};
      else if (regHit(paddr, OFF_IRQ_STATUS))
         readValue = {10'h000, irqStatus};
      else if (regHit(paddr, OFF_IRQ_MASK))
         readValue = {10'h000, irqMask};
      else
         addrHit = 1'b0;
   end

   // one wait-free access phase: answer is registered in the setup cycle
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end
      else
      begin
         pready <= setupPhase;
         if (setupPhase)
         begin
            pslverr <= !addrHit;
            prdata <= {16'h0000, readValue};
         end
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         debounceCtrl <= REG_RESET;
         polRearm <= REG_RESET;
         keySel0 <= REG_RESET;
         keySel1 <= REG_RESET;
         keySel2 <= 8'h00;
         irqMask <= 6'h00;
      end
      else if (wrDone)
      begin
         if (regHit(paddr, OFF_DEBOUNCE))
            debounceCtrl <= pwdata[15:0] & DEBOUNCE_WMASK;
         if (regHit(paddr, OFF_POL_REARM))
            polRearm <= pwdata[15:0] & POL_REARM_WMASK;
         if (regHit(paddr, OFF_KEY_SEL0))
            keySel0 <= pwdata[15:0];
         if (regHit(paddr, OFF_KEY_SEL1))
            keySel1 <= pwdata[15:0];
         if (regHit(paddr, OFF_KEY_SEL2))
            keySel2 <= pwdata[7:0] & KEY_SEL2_WMASK[7:0];
         if (regHit(paddr, OFF_IRQ_MASK))
            irqMask <= pwdata[CHANNELS-1:0];
      end
   end

   for (genvar n = 0; n < PIN_IRQS; n++)
   begin : g_source
      always_ff @(posedge clk)
      begin
         if (rst)
            irqSource[n] <= SEL_RESET;
         else if (wrDone && regHit(paddr, OFF_SEL_IRQ0 + 32'(2 * n)))
            irqSource[n] <= pwdata[SEL_W-1:0];
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         tickCount <= '0;
         msTick <= 1'b0;
      end
      else
      begin
         msTick <= (tickCount == 17'(TICK_CYCLES - 1));
         if (tickCount == 17'(TICK_CYCLES - 1))
            tickCount <= '0;
         else
            tickCount <= tickCount + 17'h00001;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         pinMeta <= '0;
         pinSync <= '0;
      end
      else
      begin
         pinMeta <= {port3, port2, port1, port0};
         pinSync <= pinMeta;
      end
   end

   assign keyEnable = {keySel2, keySel1[9:0], keySel1[15:PORT1_LSB], keySel0[7:0]};

   assign keyRaw = |(keyEnable & (pinSync ^ {PINS{keySel0[KEY_POL_BIT]}}));

   for (genvar n = 0; n < PIN_IRQS; n++)
   begin : g_pin
      // pin polarity
      // selectors above the last pin pick nothing, whatever the polarity
      assign rawActive[n] = (irqSource[n] != 6'h00) && (irqSource[n] <= 6'h20) &&
         (pickPin(pinSync, irqSource[n]) ^ polRearm[n]);
      assign pinSet[n] = qualified[n] && !pinIrq[n] && (armed[n] || !polRearm[REARM_LSB + n]);
      assign pinClr[n] = wrDone && regHit(paddr, OFF_IRQ_ACK) && pwdata[n];

      always_ff @(posedge clk)
      begin
         if (rst)
            armed[n] <= 1'b1;
         else if (pinSet[n])
            armed[n] <= 1'b0;
         else if (!qualified[n])
            armed[n] <= 1'b1;
      end

      always_ff @(posedge clk)
      begin
         if (rst)
            pinIrq[n] <= 1'b0;
         else
            pinIrq[n] <= pinSet[n] || (pinIrq[n] && !pinClr[n]);
      end
   end
   assign rawActive[CHANNELS-1] = keyRaw;

   for (genvar c = 0; c < CHANNELS; c++)
   begin : g_deb
      gkirq_debounce u_deb (
         .clk(clk),
         .rst(rst),
         .msTick(msTick),
         .enable(debounceCtrl[DEB_EN_LSB + c]),
         .period(debounceCtrl[DEB_PERIOD_LSB +: SEL_W]),
         .raw(rawActive[c]),
         .qual(qualified[c])
      );
   end

   assign keyDown = qualified[CHANNELS-1];
   assign keyPress = keyDown && !keyDownPrev;
   assign keyRelease = !keyDown && keyDownPrev && keySel0[KEY_REL_BIT];
   assign repeatFire = keyDown && keyDownPrev && repeatPeriod != 6'h00 && msTick &&
      repeatCount == repeatPeriod - 6'h01;
   assign keyEvent = keyPress || keyRelease || repeatFire;

   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         keyDownPrev <= 1'b0;
         repeatCount <= '0;
      end
      else
      begin
         keyDownPrev <= keyDown;
         if (keyDown != keyDownPrev || !keyDown || repeatFire)
            repeatCount <= '0;
         else if (msTick && repeatCount < 6'h3f)
            repeatCount <= repeatCount + 6'h01;
      end
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         keypadInterrupt <= 1'b0;
      else
         keypadInterrupt <= keyEvent ||
            (keypadInterrupt && !(wrDone && regHit(paddr, OFF_IRQ_ACK) && pwdata[KEY_ACK_BIT]));
   end

   // sticky status, cleared by reading it; new events win over the clear
   always_ff @(posedge clk)
   begin
      if (rst)
         irqStatus <= 6'h00;
      else
         irqStatus <= {keyEvent, pinSet} |
            (irqStatus & ~{CHANNELS{rdDone && regHit(paddr, OFF_IRQ_STATUS)}});
   end

   always_ff @(posedge clk)
   begin
      if (rst)
         irq <= 1'b0;
      else
         irq <= |(irqStatus & irqMask);
   end

   ack_clear_a: assert property (@(posedge clk) disable iff (rst)
      pinClr[0] && !pinSet[0] |=> !pinIrq[0])
      else $error("pin interrupt 0 not cleared by acknowledge");
   key_ack_a: assert property (@(posedge clk) disable iff (rst)
      wrDone && regHit(paddr, OFF_IRQ_ACK) && pwdata[KEY_ACK_BIT] && !keyEvent |=> !keypadInterrupt)
      else $error("keypad interrupt not cleared by acknowledge");
   ack_read_a: assert property (@(posedge clk) disable iff (rst)
      setupPhase && !pwrite && regHit(paddr, OFF_IRQ_ACK) |=> pready && prdata == 32'h00000000)
      else $error("acknowledge register read nonzero");
   rearm_wait_a: assert property (@(posedge clk) disable iff (rst)
      polRearm[REARM_LSB] && !armed[0] |-> !pinSet[0])
      else $error("pin interrupt 0 re-fired before release");
   pin_level_a: assert property (@(posedge clk) disable iff (rst)
      $rose(qualified[0]) |-> $past(pickPin(pinSync, irqSource[0]) ^ polRearm[0]))
      else $error("pin interrupt 0 qualified at the wrong input level");
   release_off_a: assert property (@(posedge clk) disable iff (rst)
      !keyDown && !keySel0[KEY_REL_BIT] |-> !keyEvent)
      else $error("keypad interrupt raised on release while disabled");
   repeat_off_a: assert property (@(posedge clk) disable iff (rst)
      repeatPeriod == 6'h00 |-> !repeatFire)
      else $error("repeat fired with repeat disabled");
   repeat_gap_a: assert property (@(posedge clk) disable iff (rst)
      repeatFire |-> keyDown && repeatCount == repeatPeriod - 6'h01)
      else $error("repeat fired at the wrong count");
   no_source_a: assert property (@(posedge clk) disable iff (rst)
      irqSource[0] == 6'h00 |-> !rawActive[0])
      else $error("unselected pin interrupt saw an input");
   sticky_key_a: assert property (@(posedge clk) disable iff (rst)
      keypadInterrupt && !(wrDone && regHit(paddr, OFF_IRQ_ACK)) |=> keypadInterrupt)
      else $error("keypad interrupt dropped without acknowledge");
   tick_space_a: assert property (@(posedge clk) disable iff (rst)
      msTick |=> !msTick)
      else $error("millisecond tick on adjacent cycles");
endmodule

// ---- tb/gkirq_pins.sv ----
`timescale 1ns/1ps
module gkirq_pins
(
   input wire logic clk,
   input wire logic [31:0] level,
   output logic [7:0] port0,
   output logic [5:0] port1,
   output logic [9:0] port2,
   output logic [7:0] port3
);
   // keys move only after an edge, so the synchroniser sees clean steps
   always_ff @(posedge clk)
   begin
      port0 <= level[7:0];
      port1 <= level[13:8];
      port2 <= level[23:14];
      port3 <= level[31:24];
   end
endmodule

// ---- tb/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   import gkirq_pkg::*;
   typedef struct packed {logic [31:0] a; logic [15:0] d; logic [15:0] e;} gkirq_row_t;
   // short tick keeps millisecond timers cheap in simulation
   localparam int TCK = 10;
   logic clk, rst, psel, penable, pwrite, pready, pslverr, err, keypadInterrupt, irq;
   logic [15:0] paddr;
   logic [31:0] pwdata, prdata, rd, level;
   logic [7:0] port0, port3;
   logic [5:0] port1;
   logic [9:0] port2;
   logic [4:0] pinIrq;
   int failures, cmp_count;
   gkirq_row_t rows [8];
   gkirq_row_t keys [5];

   gkirq_logic #(.TICK_CYCLES(TCK)) gkirq_logic_i (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .port0(port0), .port1(port1), .port2(port2), .port3(port3), .pinIrq(pinIrq),
      .keypadInterrupt(keypadInterrupt), .irq(irq));
   gkirq_pins gkirq_pins_i (.clk(clk), .level(level), .port0(port0), .port1(port1), .port2(port2),
      .port3(port3));

   function automatic logic [15:0] ad(input logic [31:0] off);
      return {2'b00, off[11:0], 2'b00};
   endfunction
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp)
      begin
         failures++;
         $display("ERROR %0t: seen %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [15:0] a, input logic [15:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= {16'h0000, d};
      @(posedge clk);
      penable <= 1'b1;
      n = 0;
      do
      begin
         @(posedge clk);
         n++;
      end
      while (pready !== 1'b1 && n < 20);
      if (n >= 20)
      begin
         failures++;
         $display("ERROR %0t: bus transfer never answered", $time);
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(input logic [31:0] off, input logic [15:0] d);
      apb(1'b1, ad(off), d);
   endtask
   task automatic rdchk(input logic [31:0] off, input logic [15:0] e);
      apb(1'b0, ad(off), 16'h0000);
      chk(rd, {16'h0000, e});
   endtask
   task automatic chkIrq(input logic [5:0] e);
      chk({26'h0, keypadInterrupt, pinIrq}, {26'h0, e});
   endtask
   task automatic summarize;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial
   begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial
   begin
      #400000;
      $display("ERROR %0t: watchdog expired", $time);
      failures++;
      summarize();
   end
   initial
   begin
      rst = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 16'h0000;
      pwdata = 32'h0;
      level = 32'h0;
      failures = 0;
      cmp_count = 0;
      // the port 0 select row raises a keypad press that the ack row clears
      rows = '{'{OFF_SEL_IRQ0, 16'hffff, 16'h003f}, '{OFF_KEY_SEL0, 16'hffff, 16'hffff},
         '{OFF_DEBOUNCE, 16'hffff, DEBOUNCE_WMASK},
         '{OFF_IRQ_ACK, 16'h003f, 16'h0000}, '{OFF_POL_REARM, 16'hffff, POL_REARM_WMASK},
         '{OFF_KEY_SEL1, 16'hffff, 16'hffff}, '{OFF_KEY_SEL2, 16'hffff, KEY_SEL2_WMASK},
         '{OFF_IRQ_MASK, 16'h003f, 16'h003f}};
      keys = '{'{OFF_KEY_SEL0, 16'h0080, 16'd7}, '{OFF_KEY_SEL1, 16'h8000, 16'd13},
         '{OFF_KEY_SEL1, 16'h0001, 16'd14}, '{OFF_KEY_SEL1, 16'h0200, 16'd23},
         '{OFF_KEY_SEL2, 16'h0001, 16'd24}};
      cyc(4);
      rst <= 1'b0;
      chkIrq(6'h00);
      foreach (rows[i])
      begin
         rdchk(rows[i].a, REG_RESET);
         wr(rows[i].a, rows[i].d);
         rdchk(rows[i].a, rows[i].e);
         wr(rows[i].a, 16'h0000);
      end
      apb(1'b0, 16'h3ffc, 16'h0000);
      chk({31'h0, err}, 32'h1);
      $display("test registers done");
      // selector 32 is the last pin of port 3
      wr(OFF_SEL_IRQ0, 16'h0001);
      wr(OFF_SEL_IRQ4, 16'h0020);
      level <= 32'h8000_0001;
      cyc(8);
      chkIrq(6'h11);
      level <= 32'h0;
      cyc(8);
      wr(OFF_IRQ_ACK, 16'h0000);
      chkIrq(6'h11);
      wr(OFF_IRQ_ACK, 16'h0011);
      cyc(2);
      chkIrq(6'h00);
      wr(OFF_POL_REARM, 16'h0011);
      cyc(8);
      chkIrq(6'h11);
      level <= 32'h8000_0001;
      cyc(8);
      wr(OFF_IRQ_ACK, 16'h0011);
      cyc(2);
      chkIrq(6'h00);
      wr(OFF_POL_REARM, 16'h0000);
      wr(OFF_SEL_IRQ4, 16'h0000);
      $display("test pin polarity done");
      level <= 32'h1;
      // pin 4 latched again before its selector went to zero
      wr(OFF_IRQ_ACK, 16'h0011);
      cyc(8);
      chkIrq(6'h01);
      wr(OFF_POL_REARM, 16'h0100);
      wr(OFF_IRQ_ACK, 16'h0001);
      cyc(8);
      chkIrq(6'h00);
      level <= 32'h0;
      cyc(8);
      level <= 32'h1;
      cyc(8);
      chkIrq(6'h01);
      level <= 32'h0;
      wr(OFF_IRQ_ACK, 16'h0001);
      wr(OFF_POL_REARM, 16'h0000);
      wr(OFF_SEL_IRQ0, 16'h0000);
      $display("test rearm done");
      foreach (keys[i])
      begin
         wr(keys[i].a, keys[i].d);
         level <= 32'h1 << keys[i].e[4:0];
         cyc(8);
         chkIrq(6'h20);
         level <= 32'h0;
         wr(OFF_IRQ_ACK, 16'h0020);
         wr(keys[i].a, 16'h0000);
      end
      wr(OFF_KEY_SEL0, 16'h0080);
      level <= 32'h0000_0001;
      cyc(8);
      chkIrq(6'h00);
      level <= 32'h0000_00ff;
      wr(OFF_KEY_SEL0, 16'h4080);
      wr(OFF_IRQ_ACK, 16'h0020);
      level <= 32'h0000_007f;
      cyc(8);
      chkIrq(6'h20);
      wr(OFF_KEY_SEL0, 16'h0080);
      wr(OFF_IRQ_ACK, 16'h0020);
      $display("test keypad pins done");
      level <= 32'h80;
      cyc(8);
      wr(OFF_IRQ_ACK, 16'h0020);
      cyc(50);
      chkIrq(6'h00);
      level <= 32'h0;
      cyc(8);
      chkIrq(6'h00);
      // repeat of 4 ms fires 30 to 40 cycles after the press
      wr(OFF_KEY_SEL0, 16'h0480);
      level <= 32'h80;
      cyc(8);
      chkIrq(6'h20);
      wr(OFF_IRQ_ACK, 16'h0020);
      cyc(10);
      chkIrq(6'h00);
      cyc(26);
      chkIrq(6'h20);
      wr(OFF_KEY_SEL0, 16'h8080);
      level <= 32'h0;
      wr(OFF_IRQ_ACK, 16'h0020);
      cyc(8);
      chkIrq(6'h20);
      wr(OFF_IRQ_ACK, 16'h0020);
      $display("test repeat and release done");
      apb(1'b0, ad(OFF_IRQ_STATUS), 16'h0000);
      wr(OFF_DEBOUNCE, 16'h2003);
      level <= 32'h80;
      cyc(12);
      chkIrq(6'h00);
      cyc(30);
      chkIrq(6'h20);
      wr(OFF_IRQ_ACK, 16'h0020);
      level <= 32'h0;
      cyc(12);
      chkIrq(6'h00);
      cyc(30);
      chkIrq(6'h20);
      chk({31'h0, irq}, 32'h0);
      wr(OFF_IRQ_MASK, 16'h0020);
      cyc(2);
      chk({31'h0, irq}, 32'h1);
      rdchk(OFF_IRQ_STATUS, 16'h0020);
      cyc(2);
      chk({31'h0, irq}, 32'h0);
      $display("test debounce and status done");
      rst <= 1'b1;
      cyc(2);
      rst <= 1'b0;
      cyc(1);
      chkIrq(6'h00);
      rdchk(OFF_POL_REARM, REG_RESET);
      rdchk(OFF_KEY_SEL0, REG_RESET);
      $display("test second reset done");
      summarize();
   end
endmodule
